/* shared/fppp_pkg.sv */
// Package: constants and types for the flash parallel programming port
package fppp_pkg;
  localparam int          FPPP_ADDR_W      = 10;
  localparam int          FPPP_DATA_W      = 8;
  localparam int          FPPP_DEPTH       = 1024;
  localparam logic [7:0]  FPPP_ERASED_BYTE = 8'hff;
  localparam int          FPPP_CLK_HZ      = 40000000;
  // Self-timed byte/lock write, typical figure in microseconds
  localparam int          FPPP_WRITE_US    = 1200;
  localparam int          FPPP_WRITE_CYC   =
    (FPPP_CLK_HZ / 1000000) * FPPP_WRITE_US;
  // Least erase strobe width in microseconds, scaled to cycles by the whole MHz count
  localparam int          FPPP_ERASE_US    = 10000;
  localparam int          FPPP_ERASE_CYC   =
    (FPPP_CLK_HZ / 1000000) * FPPP_ERASE_US;
  localparam int          FPPP_CNT_W       = 20;
  // Mode codes, bit order {sel_a, sel_b, sel_c, sel_d}
  localparam logic [3:0]  FPPP_MODE_WRITE  = 4'h7;
  localparam logic [3:0]  FPPP_MODE_READ   = 4'h3;
  localparam logic [3:0]  FPPP_MODE_LOCK1  = 4'hf;
  localparam logic [3:0]  FPPP_MODE_LOCK2  = 4'hc;
  localparam logic [3:0]  FPPP_MODE_ERASE  = 4'h8;
  localparam logic [3:0]  FPPP_MODE_SIG    = 4'h0;
  localparam logic [9:0]  FPPP_SIG_ADDR0   = 10'h000;
  localparam logic [9:0]  FPPP_SIG_ADDR1   = 10'h001;
  localparam logic [9:0]  FPPP_SIG_ADDR2   = 10'h002;

  typedef struct packed {
    logic       sel_a;
    logic       sel_b;
    logic       sel_c;
    logic       sel_d;
  } fppp_mode_t;

  typedef struct packed {
    logic       lock_bit_first;
    logic       lock_bit_second;
  } fppp_lock_t;
endpackage : fppp_pkg

/* rtl/fppp_mem.sv */
// Code array storage with registered read data
module fppp_mem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk_sys,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: erase is done by the owner walking it
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fppp_mem

/* rtl/fppp_port.sv */
// Parallel programming port of the on-chip code flash
module fppp_port
  import fppp_pkg::*;
#(
  parameter int         WRITE_CYC = FPPP_WRITE_CYC,
  parameter int         ERASE_CYC = FPPP_ERASE_CYC,
  // Identity bytes: arbitrary values
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,
  parameter logic [7:0] SIG_BYTE1 = 8'ha5,
  parameter logic [7:0] SIG_BYTE2 = 8'h3c
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Programming pins
  input  wire logic       reset_high_pin,
  input  wire logic       vpp_high_pin,
  input  wire logic       strobe_pin,
  input  wire logic       address_advance_pin,
  input  wire fppp_mode_t mode_pins,
  // Data port, two-way
  input  wire logic [7:0] code_data_port_in,
  output logic      [7:0] code_data_port_out,
  output logic            code_data_port_oe,
  // Status
  output logic            ready_busy_pin
);
  typedef enum logic [2:0] {
    FPPP_IDLE, FPPP_WRITE, FPPP_ERASE_HOLD, FPPP_ERASE_WALK
  } fppp_state_t;

  fppp_state_t           state_reg;
  fppp_lock_t            lock_reg;
  logic [2:0]            rst_s, strb_s, adv_s;
  logic [1:0]            vpp_s;
  logic [1:0][3:0]       mode_s;
  logic [7:0]            data_s1, data_s2;
  logic                  rst_q, strb_q, adv_q;
  logic [FPPP_ADDR_W-1:0] addr_reg, last_addr_reg, walk_reg;
  logic [7:0]            last_data_reg;
  logic [FPPP_CNT_W-1:0] cnt_reg;
  logic [FPPP_CNT_W-1:0] write_age_reg;
  logic                  mem_we;
  logic [FPPP_ADDR_W-1:0] mem_waddr;
  logic [7:0]            mem_wdata, mem_rdata;
  logic [3:0]            mode;
  logic                  rst_rise, strb_fall, strb_rise, adv_rise;
  logic                  prog_ok, read_en, busy;
  logic [7:0]            read_val, read_next;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s   <= '0;
      vpp_s   <= '0;
      strb_s  <= 3'h7;
      adv_s   <= '0;
      mode_s  <= '0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      rst_s   <= {rst_s[1:0], reset_high_pin};
      vpp_s   <= {vpp_s[0], vpp_high_pin};
      strb_s  <= {strb_s[1:0], strobe_pin};
      adv_s   <= {adv_s[1:0], address_advance_pin};
      mode_s  <= {mode_s[0], {mode_pins.sel_a, mode_pins.sel_b,
                  mode_pins.sel_c, mode_pins.sel_d}};
      data_s1 <= code_data_port_in;
      data_s2 <= data_s1;
    end
  end

  always_comb begin
    mode = mode_s[1];
  end
  assign rst_q     = rst_s[1];
  assign strb_q    = strb_s[1];
  assign adv_q     = adv_s[1];
  assign rst_rise  = rst_s[1] & ~rst_s[2];
  assign strb_fall = ~strb_s[1] & strb_s[2];
  assign strb_rise = strb_s[1] & ~strb_s[2];
  assign adv_rise  = adv_s[1] & ~adv_s[2];
  assign prog_ok   = rst_q & vpp_s[1];
  assign busy      = (state_reg != FPPP_IDLE);

  // Address counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
    end else if (rst_rise) begin
      addr_reg <= '0;
    end else if (adv_rise && rst_q) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // Sequencer: strobe rise starts a write, low strobe times erase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FPPP_IDLE;
      cnt_reg   <= '0;
      walk_reg  <= '0;
    end else begin
      unique case (state_reg)
        FPPP_IDLE: begin
          cnt_reg  <= '0;
          walk_reg <= '0;
          if (prog_ok && strb_fall && mode == FPPP_MODE_ERASE) begin
            state_reg <= FPPP_ERASE_HOLD;
          end else if (prog_ok && strb_rise &&
                       (mode == FPPP_MODE_WRITE ||
                        mode == FPPP_MODE_LOCK1 ||
                        mode == FPPP_MODE_LOCK2)) begin
            state_reg <= FPPP_WRITE;
          end
        end
        FPPP_WRITE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == FPPP_CNT_W'(WRITE_CYC - 1)) begin
            state_reg <= FPPP_IDLE;
          end
        end
        FPPP_ERASE_HOLD: begin
          // Short strobe aborts erase: nothing changes
          if (strb_q || !prog_ok) begin
            state_reg <= FPPP_IDLE;
          end else if (cnt_reg == FPPP_CNT_W'(ERASE_CYC - 1)) begin
            state_reg <= FPPP_ERASE_WALK;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FPPP_ERASE_WALK: begin
          walk_reg <= walk_reg + 1'b1;
          if (walk_reg == FPPP_ADDR_W'(FPPP_DEPTH - 1)) begin
            state_reg <= FPPP_IDLE;
          end
        end
      endcase
    end
  end

  // Lock bits and last-write capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg      <= '0;
      last_addr_reg <= '0;
      last_data_reg <= '0;
    end else if (state_reg == FPPP_ERASE_HOLD && !strb_q && prog_ok &&
                 cnt_reg == FPPP_CNT_W'(ERASE_CYC - 1)) begin
      lock_reg <= '0;
    end else if (state_reg == FPPP_IDLE && prog_ok && strb_rise) begin
      if (mode == FPPP_MODE_LOCK1) begin
        lock_reg.lock_bit_first <= 1'b1;
      end
      if (mode == FPPP_MODE_LOCK2) begin
        lock_reg.lock_bit_second <= 1'b1;
      end
      if (mode == FPPP_MODE_WRITE && !lock_reg.lock_bit_first) begin
        last_addr_reg <= addr_reg;
        last_data_reg <= data_s2;
      end
    end
  end
  // Lock state is only ever used to gate actions, never driven out

  // Flash cells only pull bits low; restoring ones needs erase
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = addr_reg;
    mem_wdata = data_s2 & mem_rdata;
    if (state_reg == FPPP_ERASE_WALK) begin
      mem_we    = 1'b1;
      mem_waddr = walk_reg;
      mem_wdata = FPPP_ERASED_BYTE;
    end else if (state_reg == FPPP_IDLE && prog_ok && strb_rise &&
                 mode == FPPP_MODE_WRITE &&
                 !lock_reg.lock_bit_first) begin
      mem_we = 1'b1;
    end
  end

  fppp_mem #(
    .AW (FPPP_ADDR_W),
    .DW (FPPP_DATA_W)
  ) u_mem (
    .clk_sys (clk_sys),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (addr_reg),
    .rdata   (mem_rdata)
  );

  // Read path: verify, data polling and signature
  assign read_en = rst_q && !vpp_s[1] && strb_q &&
                   (mode == FPPP_MODE_READ || mode == FPPP_MODE_SIG);
  always_comb begin
    read_next = mem_rdata;
    if (mode == FPPP_MODE_SIG) begin
      unique case (addr_reg)
        FPPP_SIG_ADDR0: read_next = SIG_BYTE0;
        FPPP_SIG_ADDR1: read_next = SIG_BYTE1;
        FPPP_SIG_ADDR2: read_next = SIG_BYTE2;
        default:        read_next = mem_rdata;
      endcase
    end else if (lock_reg.lock_bit_first &&
                 lock_reg.lock_bit_second) begin
      read_next = '0;
    end else if (state_reg == FPPP_WRITE &&
                 addr_reg == last_addr_reg) begin
      read_next = {~last_data_reg[7], mem_rdata[6:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      read_val <= '0;
    end else begin
      read_val <= read_next;
    end
  end

  assign code_data_port_out = read_val;
  assign code_data_port_oe  = read_en;
  assign ready_busy_pin     = ~busy;

  // Checks

  // Cycles spent in the write, saturating so a hang cannot wrap to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_age_reg <= '0;
    end else if (state_reg != FPPP_WRITE) begin
      write_age_reg <= '0;
    end else if (write_age_reg != '1) begin
      write_age_reg <= write_age_reg + 1'b1;
    end
  end
  a_lock_blocks_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    lock_reg.lock_bit_first && state_reg != FPPP_ERASE_WALK
    |-> !mem_we) else $error("write despite lock");
  a_verify_blocked: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    lock_reg.lock_bit_first && lock_reg.lock_bit_second &&
    mode == FPPP_MODE_READ && $stable(mode)
    |=> read_val == 8'h00) else $error("verify despite lock");
  a_lock_clear_erase: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(lock_reg.lock_bit_first) |-> $past(state_reg) == FPPP_ERASE_HOLD)
    else $error("lock cleared without erase");
  a_erase_ones: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == FPPP_ERASE_WALK |-> mem_wdata == FPPP_ERASED_BYTE)
    else $error("erase data not ones");
  a_addr_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    rst_rise |=> addr_reg == '0) else $error("address not cleared");
  a_addr_step: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    adv_rise && rst_q && !rst_rise |=> addr_reg == $past(addr_reg) + 1'b1)
    else $error("address not advanced");
  a_busy_after_strobe: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    mem_we && state_reg == FPPP_IDLE |=> !ready_busy_pin[*8])
    else $error("busy not shown");
  a_write_ends: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == FPPP_WRITE
    |-> write_age_reg < FPPP_CNT_W'(WRITE_CYC))
    else $error("write never ends");
  a_poll_invert: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == FPPP_WRITE && addr_reg == last_addr_reg &&
    mode == FPPP_MODE_READ && !(&lock_reg)
    |=> read_val[7] == ~last_data_reg[7]) else $error("poll bit wrong");
  a_sig_first: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    mode == FPPP_MODE_SIG && addr_reg == FPPP_SIG_ADDR0
    |=> read_val == SIG_BYTE0) else $error("signature byte wrong");
  a_erase_abort: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == FPPP_ERASE_HOLD && strb_q |=> state_reg == FPPP_IDLE)
    else $error("erase not aborted");
  c_write: cover property (@(posedge clk_sys) state_reg == FPPP_WRITE);
  c_erase: cover property (@(posedge clk_sys) state_reg == FPPP_ERASE_WALK);
  c_read:  cover property (@(posedge clk_sys) read_en);
  c_poll:  cover property (@(posedge clk_sys)
    state_reg == FPPP_WRITE && read_en);
  c_refused: cover property (@(posedge clk_sys)
    lock_reg.lock_bit_first && state_reg == FPPP_WRITE);
endmodule : fppp_port

/* bench/fppp_prog.sv */
// Programmer model that drives the programming pins
module fppp_prog
  import fppp_pkg::*;
(
  // Clock
  input  wire logic clk_sys,
  // Pins to the device
  output fppp_mode_t mode_pins,
  output logic       reset_high_pin,
  output logic       vpp_high_pin,
  output logic       strobe_pin,
  output logic       address_advance_pin,
  // Data port drive
  output logic [7:0] drv_data,
  output logic       drv_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mode_pins = FPPP_MODE_READ;
    reset_high_pin = 1'b0;
    vpp_high_pin = 1'b0;
    strobe_pin = 1'b1;
    address_advance_pin = 1'b0;
    drv_data = 8'h00;
    drv_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic enter();
    reset_high_pin = 1'b0;
    vpp_high_pin = 1'b0;
    tick(4);
    reset_high_pin = 1'b1;
    tick(4);
  endtask : enter
  // Drop to logic high and release the port before reading
  task automatic set_read(input logic [3:0] m);
    vpp_high_pin = 1'b0;
    drv_oe = 1'b0;
    mode_pins = m;
    tick(6);
  endtask : set_read
  // Data first, then high voltage, then one strobe
  task automatic strobe_op(input logic [3:0] m, input logic [7:0] d,
                           input int w);
    mode_pins = m;
    drv_data = d;
    drv_oe = 1'b1;
    tick(2);
    vpp_high_pin = 1'b1;
    tick(2);
    strobe_pin = 1'b0;
    tick(w);
    strobe_pin = 1'b1;
  endtask : strobe_op
  // Wide pulse so the synchroniser cannot miss it
  task automatic advance();
    address_advance_pin = 1'b1;
    tick(4);
    address_advance_pin = 1'b0;
    tick(8);
  endtask : advance
endmodule : fppp_prog

/* bench/testbench.sv */
// Testbench: programmer model, reference model and checks
module testbench;
  import fppp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 20;
  localparam int EC = 10;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  fppp_mode_t mode_pins;
  logic       reset_high_pin, vpp_high_pin, strobe_pin;
  logic       address_advance_pin, code_data_port_oe, ready_busy_pin;
  logic       drv_oe;
  logic [7:0] code_data_port_out, drv_data, port_w;
  logic [7:0] mem_m [FPPP_DEPTH];
  logic [7:0] sig_e [3] = '{8'h5a, 8'ha5, 8'h3c};
  logic       lk1, lk2;
  int         num_errors = 0;
  int         comparisons = 0;
  int         seed = 32'h05e2ba00;
  always #12.5 clk_sys = ~clk_sys;
  // Pull-ups hold the port high when nobody drives it
  assign port_w = code_data_port_oe ? code_data_port_out :
                  (drv_oe ? drv_data : 8'hff);
  fppp_port #(.WRITE_CYC(WC), .ERASE_CYC(EC)) DUT (
    .clk_sys, .rst_n, .reset_high_pin, .vpp_high_pin, .strobe_pin,
    .address_advance_pin, .mode_pins, .code_data_port_in(port_w),
    .code_data_port_out, .code_data_port_oe, .ready_busy_pin);
  fppp_prog prog (.clk_sys, .mode_pins, .reset_high_pin, .vpp_high_pin,
    .strobe_pin, .address_advance_pin, .drv_data, .drv_oe);
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (ready_busy_pin !== 1'b1 && n < lim) begin
      prog.tick(1);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("CHECK FAILED ready expected 1 seen timeout");
      summarize();
    end
  endtask : wait_ready
  function automatic logic [7:0] exp_rd(input int a);
    return (lk1 && lk2) ? 8'h00 : mem_m[a];
  endfunction : exp_rd
  task automatic verify(input int n);
    prog.enter();
    prog.set_read(FPPP_MODE_READ);
    check("oe", {7'h0, code_data_port_oe}, 8'h01);
    for (int i = 0; i < n; i++) begin
      check("verify", code_data_port_out, exp_rd(i));
      prog.advance();
    end
  endtask : verify
  task automatic write_op(input logic [3:0] m, input logic [7:0] d,
                          input int a);
    prog.strobe_op(m, d, 5);
    prog.tick(5);
    check("busy", {7'h0, ready_busy_pin}, 8'h00);
    if (m == FPPP_MODE_WRITE && !lk1) begin
      prog.set_read(FPPP_MODE_READ);
      check("poll", {7'h0, code_data_port_out[7]}, {7'h0, ~d[7]});
    end
    wait_ready(WC + 40);
    if (m == FPPP_MODE_WRITE && !lk1) mem_m[a] = mem_m[a] & d;
    if (m == FPPP_MODE_LOCK1) lk1 = 1'b1;
    if (m == FPPP_MODE_LOCK2) lk2 = 1'b1;
    prog.set_read(FPPP_MODE_READ);
    check("true", code_data_port_out, exp_rd(a));
  endtask : write_op
  // Short hold must leave array and locks alone
  task automatic erase_op(input int w);
    prog.strobe_op(FPPP_MODE_ERASE, 8'h00, w);
    wait_ready(2000);
    if (w > EC) begin
      foreach (mem_m[i]) mem_m[i] = FPPP_ERASED_BYTE;
      lk1 = 1'b0;
      lk2 = 1'b0;
    end
  endtask : erase_op
  initial begin
    lk1 = 1'b0;
    lk2 = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    check("ready", {7'h0, ready_busy_pin}, 8'h01);
    prog.enter();
    erase_op(EC + 6);
    verify(6);
    $display("Test erase done");
    prog.enter();
    for (int i = 0; i < 4; i++) begin
      write_op(FPPP_MODE_WRITE, 8'($random(seed)), i);
      prog.advance();
    end
    prog.enter();
    write_op(FPPP_MODE_WRITE, 8'($random(seed)), 0);
    verify(5);
    $display("Test write done");
    prog.enter();
    prog.set_read(FPPP_MODE_SIG);
    for (int i = 0; i < 4; i++) begin
      check("sig", code_data_port_out, i < 3 ? sig_e[i] : exp_rd(3));
      prog.advance();
    end
    $display("Test signature done");
    prog.enter();
    write_op(FPPP_MODE_LOCK1, 8'h00, 0);
    write_op(FPPP_MODE_WRITE, 8'h00, 0);
    verify(2);
    prog.enter();
    write_op(FPPP_MODE_LOCK2, 8'h00, 0);
    verify(2);
    erase_op(4);
    verify(1);
    erase_op(EC + 6);
    verify(2);
    prog.enter();
    write_op(FPPP_MODE_WRITE, 8'($random(seed)), 0);
    verify(2);
    $display("Test locks done");
    summarize();
  end
endmodule : testbench
